/* rtl/msdh_consts.svh */
// timing constants of the start-of-message handshake sequencer
`ifndef MSDH_CONSTS_SVH
`define MSDH_CONSTS_SVH

// ****************************************
// clock
// ****************************************
`define MSDH_CLK_PERIOD_NS 10
// nominal device system clock period; the delays after acknowledge are counted in these ticks
`define MSDH_SYS_PERIOD_NS 50
`define MSDH_SYS_DIV (`MSDH_SYS_PERIOD_NS / `MSDH_CLK_PERIOD_NS)

// ****************************************
// delays from command mid-parity
// ****************************************
`define MSDH_REQ_DELAY_NS 1500
`define MSDH_REQ_DELAY_MIN_NS 1250
`define MSDH_REQ_DELAY_MAX_NS 2100
`define MSDH_REQ_CYC ((`MSDH_REQ_DELAY_NS + `MSDH_CLK_PERIOD_NS - 1) / `MSDH_CLK_PERIOD_NS)
`define MSDH_ACT_DELAY_NS 1000
`define MSDH_ACT_CYC ((`MSDH_ACT_DELAY_NS + `MSDH_CLK_PERIOD_NS - 1) / `MSDH_CLK_PERIOD_NS)

// ****************************************
// handshake limits
// ****************************************
`define MSDH_GRANT_MAX_NS 4500
`define MSDH_GRANT_CYC (`MSDH_GRANT_MAX_NS / `MSDH_CLK_PERIOD_NS)
`define MSDH_ACK_MAX_NS 102
`define MSDH_ACK_MAX_CYC (`MSDH_ACK_MAX_NS / `MSDH_CLK_PERIOD_NS)

// ****************************************
// delays after acknowledge falls, in system ticks
// ****************************************
`define MSDH_SOM_TICKS 15
`define MSDH_IN_COMMAND_N_TICKS 8
`define MSDH_REL_TICKS 33
`define MSDH_SOM_CYC (`MSDH_SOM_TICKS * `MSDH_SYS_DIV)
`define MSDH_IN_COMMAND_N_CYC (`MSDH_IN_COMMAND_N_TICKS * `MSDH_SYS_DIV)
`define MSDH_REL_CYC (`MSDH_REL_TICKS * `MSDH_SYS_DIV)
`define MSDH_SOM_W_CYC `MSDH_SYS_DIV

`define MSDH_CNT_W 9

`endif

/* rtl/msdh_pkg.sv */
// types of the start-of-message handshake sequencer
package msdh_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_REQ,
    ST_WAIT_GRANT,
    ST_XFER,
    ST_MSG
  } msdh_state_e;

  // all pin-level strobes travel together; low-active except fail
  typedef struct packed {
    logic req_n;
    logic ack_n;
    logic som_n;
    logic active_n;
    logic in_command_n_n;
    logic fail;
  } msdh_strobes_s;

endpackage

/* rtl/msdh_counter.sv */
// phase counter: clears on request, saturates at its top value
`timescale 1ns/1ps
module msdh_counter #(
  parameter int W = 9
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         clear_i,
  output logic [W-1:0]      cnt_o
);

  wire logic         at_top;
  wire logic [W-1:0] cnt_next;

  assign at_top   = &cnt_o;
  assign cnt_next = clear_i ? '0 : (at_top ? cnt_o : W'(cnt_o + 1'b1));

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_o <= '0;
    end else begin
      cnt_o <= cnt_next;
    end
  end

endmodule

/* rtl/msdh_core.sv */
// start-of-message memory handshake sequencer of the bus monitor
`timescale 1ns/1ps
`include "msdh_consts.svh"
module msdh_core #(
  parameter int REQ_CYC   = `MSDH_REQ_CYC,
  parameter int ACT_CYC   = `MSDH_ACT_CYC,
  parameter int GRANT_CYC = `MSDH_GRANT_CYC,
  parameter int SOM_CYC   = `MSDH_SOM_CYC,
  parameter int SOM_W     = `MSDH_SOM_W_CYC,
  parameter int IN_COMMAND_N_CYC = `MSDH_IN_COMMAND_N_CYC,
  parameter int REL_CYC   = `MSDH_REL_CYC,
  parameter int CNT_W     = `MSDH_CNT_W
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic mid_parity_i,
  input  wire logic msg_done_i,
  input  wire logic mem_grant_n_i,
  output logic      mem_request_n_o,
  output logic      mem_acknowledge_n_o,
  output logic      msg_start_strobe_n_o,
  output logic      monitor_msg_active_n_o,
  output logic      in_command_n_o,
  output logic      handshake_fail_o
);

  // ****************************************
  // parameter checks
  // ****************************************
  // the active strobe is timed by the same counter that times the request,
  // so it must come first; every compare must fit below the saturation value
  if (!(ACT_CYC >= 1 && ACT_CYC < REQ_CYC && REQ_CYC < (1 << CNT_W) - 1 &&
        GRANT_CYC >= 1 && GRANT_CYC < (1 << CNT_W) - 1 && SOM_W >= 1 &&
        IN_COMMAND_N_CYC >= 1 && SOM_CYC + SOM_W < REL_CYC && IN_COMMAND_N_CYC < REL_CYC &&
        REL_CYC < (1 << CNT_W) - 1)) begin : g_bad_params
    $error("msdh_core: timing parameters out of range");
  end

  // ****************************************
  // state and counter
  // ****************************************
  msdh_pkg::msdh_state_e   state_reg;
  msdh_pkg::msdh_state_e   state_next;
  msdh_pkg::msdh_strobes_s out_reg;
  msdh_pkg::msdh_strobes_s out_next;
  logic [CNT_W-1:0]        cnt;
  logic                    cnt_clear;

  msdh_counter #(.W(CNT_W)) u_cnt (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .clear_i    (cnt_clear),
    .cnt_o      (cnt)
  );

  function automatic logic cnt_is(input logic [CNT_W-1:0] c, input int n);
    cnt_is = (c == CNT_W'(n - 1));
  endfunction

  // ****************************************
  // decoding
  // ****************************************
  wire logic cmd_start  = (state_reg == msdh_pkg::ST_IDLE) && mid_parity_i;
  wire logic req_due    = (state_reg == msdh_pkg::ST_WAIT_REQ) && cnt_is(cnt, REQ_CYC);
  wire logic act_due    = (state_reg == msdh_pkg::ST_WAIT_REQ) && cnt_is(cnt, ACT_CYC);
  wire logic granted    = (state_reg == msdh_pkg::ST_WAIT_GRANT) && !mem_grant_n_i;
  wire logic grant_late = (state_reg == msdh_pkg::ST_WAIT_GRANT) && mem_grant_n_i &&
                          cnt_is(cnt, GRANT_CYC);
  wire logic in_xfer    = (state_reg == msdh_pkg::ST_XFER);
  wire logic som_win    = in_xfer && (cnt >= CNT_W'(SOM_CYC - 1)) &&
                          (cnt < CNT_W'(SOM_CYC - 1 + SOM_W));
  wire logic in_command_n_due  = in_xfer && cnt_is(cnt, IN_COMMAND_N_CYC);
  wire logic rel_due    = in_xfer && cnt_is(cnt, REL_CYC);
  wire logic msg_end    = (state_reg == msdh_pkg::ST_MSG) && msg_done_i;

  assign cnt_clear = cmd_start || req_due || granted;

  // ****************************************
  // next state and strobes
  // ****************************************
  always_comb begin
    state_next     = state_reg;
    out_next       = out_reg;
    out_next.fail  = 1'b0;
    out_next.som_n = !som_win;
    case (state_reg)
      msdh_pkg::ST_IDLE: begin
        if (cmd_start) begin
          state_next = msdh_pkg::ST_WAIT_REQ;
        end
      end
      msdh_pkg::ST_WAIT_REQ: begin
        if (act_due) begin
          out_next.active_n = 1'b0;
        end
        if (req_due) begin
          out_next.req_n = 1'b0;
          state_next     = msdh_pkg::ST_WAIT_GRANT;
        end
      end
      msdh_pkg::ST_WAIT_GRANT: begin
        if (granted) begin
          // one cycle to acknowledge keeps well inside the grant-to-ack limit
          out_next.ack_n = 1'b0;
          state_next     = msdh_pkg::ST_XFER;
        end else if (grant_late) begin
          // the command is dropped: request withdrawn, monitor idles again
          out_next.req_n    = 1'b1;
          out_next.active_n = 1'b1;
          out_next.fail     = 1'b1;
          state_next        = msdh_pkg::ST_IDLE;
        end
      end
      msdh_pkg::ST_XFER: begin
        if (in_command_n_due) begin
          out_next.in_command_n_n = 1'b0;
        end
        if (rel_due) begin
          out_next.req_n = 1'b1;
          out_next.ack_n = 1'b1;
          state_next     = msdh_pkg::ST_MSG;
        end
      end
      msdh_pkg::ST_MSG: begin
        // message body and end handling live elsewhere; they report completion
        if (msg_end) begin
          out_next.active_n = 1'b1;
          out_next.in_command_n_n  = 1'b1;
          state_next        = msdh_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = msdh_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= msdh_pkg::ST_IDLE;
      out_reg   <= '{req_n: 1'b1, ack_n: 1'b1, som_n: 1'b1, active_n: 1'b1, in_command_n_n: 1'b1, fail: 1'b0};
    end else begin
      state_reg <= state_next;
      out_reg   <= out_next;
    end
  end

  assign mem_request_n_o        = out_reg.req_n;
  assign mem_acknowledge_n_o    = out_reg.ack_n;
  assign msg_start_strobe_n_o   = out_reg.som_n;
  assign monitor_msg_active_n_o = out_reg.active_n;
  assign in_command_n_o         = out_reg.in_command_n_n;
  assign handshake_fail_o       = out_reg.fail;

  // ****************************************
  // assertions
  // ****************************************
  localparam int ACT_A    = ACT_CYC + 1;
  localparam int REL_HOLD = REL_CYC - 1;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cmd;
    (state_reg == msdh_pkg::ST_IDLE) && mid_parity_i;
  endsequence

  sequence s_ack_fall;
    $fell(mem_acknowledge_n_o);
  endsequence

  sequence s_som_pulse;
    $fell(msg_start_strobe_n_o) ##1 (!msg_start_strobe_n_o) [*4] ##1 msg_start_strobe_n_o;
  endsequence

  property p_req_delay;
    s_cmd |-> (mem_request_n_o throughout ##REQ_CYC 1'b1) ##1 !mem_request_n_o;
  endproperty
  a_req_delay: assert property (p_req_delay) else $error("request not low at its delay");

  property p_active_delay;
    s_cmd |-> ##ACT_A $fell(monitor_msg_active_n_o);
  endproperty
  a_active_delay: assert property (p_active_delay) else $error("monitor active late or early");

  property p_ack;
    (state_reg == msdh_pkg::ST_WAIT_GRANT) && !mem_grant_n_i |=> $fell(mem_acknowledge_n_o);
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge did not follow grant");

  property p_fail;
    grant_late |=> handshake_fail_o && mem_request_n_o && monitor_msg_active_n_o &&
                   (state_reg == msdh_pkg::ST_IDLE) ##1 !handshake_fail_o;
  endproperty
  a_fail: assert property (p_fail) else $error("late grant not handled as failure");

  property p_no_ack_after_fail;
    handshake_fail_o |-> mem_acknowledge_n_o && in_command_n_o;
  endproperty
  a_no_ack_after_fail: assert property (p_no_ack_after_fail) else $error("failed command processed");

  property p_som;
    s_ack_fall |-> ##SOM_CYC s_som_pulse;
  endproperty
  a_som: assert property (p_som) else $error("start strobe misplaced or wrong width");

  property p_in_command_n;
    s_ack_fall |-> ##IN_COMMAND_N_CYC $fell(in_command_n_o);
  endproperty
  a_in_command_n: assert property (p_in_command_n) else $error("in-command timing wrong");

  property p_release;
    s_ack_fall |-> ((!mem_request_n_o && !mem_acknowledge_n_o) throughout ##REL_HOLD 1'b1) ##1
                   ($rose(mem_request_n_o) && $rose(mem_acknowledge_n_o));
  endproperty
  a_release: assert property (p_release) else $error("request and ack release timing wrong");

  property p_som_rate;
    $fell(msg_start_strobe_n_o) |-> !mem_acknowledge_n_o && !mem_request_n_o;
  endproperty
  a_som_rate: assert property (p_som_rate) else $error("start strobe outside transfer");

endmodule

/* verif/msdh_host_model.sv */
// host arbiter model that answers the sequencer's memory requests
`timescale 1ns/1ps
module msdh_host_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       mem_request_n_i,
  input  wire logic       mem_acknowledge_n_i,
  input  wire logic [9:0] grant_delay_i,
  output logic            mem_grant_n_o
);
  // ****************************************
  // grant timing
  // ****************************************
  logic [9:0] wait_reg;

  initial mem_grant_n_o = 1'b1;

  always @(posedge core_clk_i) begin
    if (!rst_n_i || mem_request_n_i) begin
      wait_reg <= #1 10'h000;
      mem_grant_n_o <= #1 1'b1;
    end else begin
      wait_reg <= #1 wait_reg + 10'h001;
      // a long wait plays a host that grants too late
      if (wait_reg == grant_delay_i) mem_grant_n_o <= #1 1'b0;
      // no hold beyond the acknowledge, like the least patient host
      if (!mem_acknowledge_n_i) mem_grant_n_o <= #1 1'b1;
    end
  end
endmodule

/* verif/tb_monitor_som_dma_handshake.sv */
// self-checking bench of the start-of-message handshake sequencer
`timescale 1ns/1ps
module tb_monitor_som_dma_handshake;
  // ****************************************
  // signals
  // ****************************************
  localparam int REQ = 12, ACT = 8, GNT = 20, SOM = 10, INC = 6, REL = 30;
  logic       core_clk, rst_n, mid_parity, msg_done, grant_n;
  logic       req_n, ack_n, som_n, act_n, in_command_n_n, fail;
  logic [9:0] grant_delay;
  logic [6:0] now_v, old_v;
  int         cyc, err_count, samples_checked;
  int         t_fall [7];
  int         t_rise [7];
  int         n_fall [7];

  msdh_core #(.REQ_CYC(REQ), .ACT_CYC(ACT), .GRANT_CYC(GNT), .SOM_CYC(SOM), .SOM_W(5),
              .IN_COMMAND_N_CYC(INC), .REL_CYC(REL)) uut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .mid_parity_i(mid_parity), .msg_done_i(msg_done),
    .mem_grant_n_i(grant_n), .mem_request_n_o(req_n), .mem_acknowledge_n_o(ack_n),
    .msg_start_strobe_n_o(som_n), .monitor_msg_active_n_o(act_n), .in_command_n_o(in_command_n_n),
    .handshake_fail_o(fail));

  msdh_host_model host (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .mem_request_n_i(req_n),
    .mem_acknowledge_n_i(ack_n), .grant_delay_i(grant_delay), .mem_grant_n_o(grant_n));

  // ****************************************
  // clock, cycle count, edge log
  // ****************************************
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    // generous bound: four commands need well under a thousand cycles
    if (cyc == 4000) begin
      err_count++;
      complete_run();
    end
  end

  // bit 6 active, 5 request, 4 grant, 3 ack, 2 in-command, 1 start, 0 fail inverted
  assign now_v = {act_n, req_n, grant_n, ack_n, in_command_n_n, som_n, ~fail};
  always @(negedge core_clk) begin
    for (int i = 0; i < 7; i++) begin
      if (old_v[i] === 1'b1 && now_v[i] === 1'b0) begin
        t_fall[i] = cyc;
        n_fall[i]++;
      end
      if (old_v[i] === 1'b0 && now_v[i] === 1'b1) t_rise[i] = cyc;
    end
    old_v = now_v;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic pulse(ref logic s);
    @(posedge core_clk);
    #1 s = 1'b1;
    @(posedge core_clk);
    #1 s = 1'b0;
  endtask

  // one command; a second crossing while busy must change nothing
  task automatic run_cmd(input logic [9:0] dly, input bit late);
    int e0;
    // step off the edge so the cycle count already holds this edge's value
    #1;
    grant_delay = dly;
    for (int i = 0; i < 7; i++) begin
      t_fall[i] = -1;
      t_rise[i] = -1;
      n_fall[i] = 0;
    end
    e0 = cyc + 2;
    pulse(mid_parity);
    pulse(mid_parity);
    repeat (REQ + GNT + REL + 20) @(posedge core_clk);
    check("active_fall", t_fall[6], e0 + ACT);
    check("request_fall", t_fall[5], e0 + REQ);
    if (late) begin
      check("fail_time", t_fall[0], t_fall[5] + GNT);
      check("fail_width", t_rise[0] - t_fall[0], 1);
      check("request_drop", t_rise[5], t_fall[0]);
      check("active_drop", t_rise[6], t_fall[0]);
      check("ack_count", n_fall[3], 0);
    end else begin
      check("ack_in_time", (t_fall[3] - t_fall[4]) inside {[1:2]}, 1);
      check("in_command_n_fall", t_fall[2], t_fall[3] + INC);
      check("start_fall", t_fall[1], t_fall[3] + SOM);
      check("start_width", t_rise[1] - t_fall[1], 5);
      check("start_count", n_fall[1], 1);
      check("request_rise", t_rise[5], t_fall[3] + REL);
      check("ack_rise", t_rise[3], t_fall[3] + REL);
      check("fail_count", n_fall[0], 0);
      pulse(msg_done);
      repeat (3) @(posedge core_clk);
    end
    #1;
    check("idle_outputs", {act_n, req_n, ack_n, in_command_n_n, som_n, fail}, 6'h3e);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    mid_parity = 1'b0;
    msg_done = 1'b0;
    grant_delay = 10'h000;
    cyc = 0;
    err_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    check("reset_outputs", {act_n, req_n, ack_n, in_command_n_n, som_n, fail}, 6'h3e);
    run_cmd(10'h000, 1'b0);
    run_cmd(10'h010, 1'b0);
    run_cmd(10'h028, 1'b1);
    run_cmd(10'h000, 1'b0);
    complete_run();
  end
endmodule
